// ===== speed_pkg.sv
// constants, field layout and carrier types of the four-channel speed unit
// assumes a 250 MHz clk_sys and a plain word-addressed register port
//
// Contract
// R1 - each channel divides its pulse train by the range-selected prescale factor
// R2 - prescaled edges drive a counter that measures the signal period
// R3 - every 100 us each period is sampled and speed is derived by division
// R4 - an averaging filter runs every 100 us to improve resolution above 200 Hz
// R5 - the same filter also yields a rate-of-change output per channel
// R6 - once per rate time newest speed and derivative go to dual-port RAM
// R7 - speed is 16 bits wide, one lsb being 0.0015 percent of range
// R8 - speed filter has two real poles; derivative adds one more pole
// R9 - four channels; input type per channel is fixed at manufacture
// R10 - after every reset the fault indicator is on; host then runs diagnostics
// R11 - failed diagnostics keep fault lit; success turns fault off, run on
// R12 - an active failure flashes the indicator a code-specific number of times
// R13 - host tells the unit each channel's rate group during initialization
// R14 - broadcast key names due rate groups; only their channels are updated
// R15 - a counter reaching its maximum reports zero speed, not a bad divide
package speed_pkg;
  localparam int N_CH = 4;
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic [9:0] FLASH_ON_MS = 10'h0FA;
  localparam logic [9:0] FLASH_OFF_MS = 10'h0FA;
  localparam logic [9:0] FLASH_GAP_MS = 10'h3E8;
  localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [31:0] SPEED_NUM = 32'h0FFF_FFFF;
  localparam logic [4:0] DIV_LAST = 5'h1F;
  localparam logic [7:0] FRAC_ZERO = 8'h00;
  localparam int DERIV_SHIFT = 6;
  localparam int FIFO_DEPTH = 32;
  // register word addresses
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_FCODE = 6'h01;
  localparam logic [5:0] A_KEY = 6'h02;
  localparam logic [5:0] A_CHCFG = 6'h04;
  localparam logic [5:0] A_DPR = 6'h10;
  // field positions
  localparam int CTRL_INIT = 0;
  localparam int CTRL_DIAG = 1;
  localparam int CFG_RANGE_LSB = 0;
  localparam int CFG_K_LSB = 2;
  localparam int CFG_GRP_LSB = 7;
  localparam int CFG_TYPE = 10;
  localparam logic [9:0] CFG_RST = 10'h018;
  localparam logic [3:0] CH_TYPE_DEF = 4'h0;

  typedef struct packed {
    logic [1:0] ch;
    logic [15:0] speed;
    logic [15:0] deriv;
  } pub_t;

  typedef enum {C_IDLE, C_DIV, C_FILT} calc_st_t;
  typedef enum {F_ON, F_OFF, F_GAP} flash_st_t;
endpackage : speed_pkg

// ===== speed_period_measure_unit.sv
// pulse prescale, period counters, divider, filters and host result RAM
// assumes pulse inputs already synchronous to clk_sys; host uses plain port
`timescale 1ns/1ns
`default_nettype none

// parameterised FIFO; ready on the fill side stalls the publisher
module pub_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count_ff != (AW+1)'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data = mem[rd_ptr_ff];

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr_ff] <= in_data;
  end
endmodule : pub_fifo

// one channel: rising-edge prescaler and period counter
module speed_chan (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pulse_in,
  input wire logic [1:0] range,
  output logic [23:0] period_ff,
  output logic stale_ff
);
  logic pulse_d_ff;
  logic [2:0] pre_ff;
  logic [23:0] cnt_ff;
  wire rise = pulse_in && !pulse_d_ff;
  wire [3:0] pre_lim = (4'h1 << range) - 4'h1;
  wire pre_edge = rise && ({1'b0, pre_ff} == pre_lim);
  wire at_max = cnt_ff == speed_pkg::CNT_MAX;

  // counter parks at max so a stopped shaft never wraps to a false speed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_d_ff <= 1'b0;
      pre_ff <= '0;
      cnt_ff <= '0;
      period_ff <= '0;
      stale_ff <= 1'b1;
    end else begin
      pulse_d_ff <= pulse_in;
      if (rise) pre_ff <= pre_edge ? 3'h0 : pre_ff + 3'h1; // R1
      if (pre_edge) begin
        period_ff <= cnt_ff; // R2
        cnt_ff <= 24'h000001;
        stale_ff <= at_max; // R15
      end else if (at_max) begin
        stale_ff <= 1'b1; // R15
      end else begin
        cnt_ff <= cnt_ff + 24'h000001;
      end
    end
  end
endmodule : speed_chan

module speed_period_measure_unit #(
  parameter int TICK_CYC = speed_pkg::TICK_CYC,
  parameter int MS_CYC = speed_pkg::MS_CYC,
  parameter logic [3:0] CH_TYPE = speed_pkg::CH_TYPE_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] pulse_in,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic fault_indicator,
  output logic run_indicator
);
  localparam int N = speed_pkg::N_CH;
  logic [9:0] cfg_ff [N];
  logic [23:0] period [N];
  logic [3:0] stale;
  logic signed [24:0] y1_ff [N];
  logic signed [24:0] y2_ff [N];
  logic signed [24:0] dv_ff [N];
  logic [15:0] spd_ram [N];
  logic [15:0] drv_ram [N];
  logic [31:0] rd_data_ff;
  logic [1:0] ctrl_ff;
  logic ok_ff;
  logic [4:0] fcode_ff;
  logic [7:0] key_ff;
  logic [3:0] pend_ff;
  logic [14:0] tick_cnt_ff;
  logic [17:0] ms_cnt_ff;
  speed_pkg::calc_st_t st_ff;
  logic [1:0] ch_ff;
  logic [4:0] bit_ff;
  logic [24:0] rem_ff;
  logic [31:0] quo_ff;
  logic [23:0] dvs_ff;
  logic bad_ff;
  speed_pkg::flash_st_t fl_ff;
  logic [9:0] fl_ms_ff;
  logic [4:0] fl_n_ff;
  logic fault_ff;
  logic run_ff;

  // channel front ends
  for (genvar c = 0; c < N; c++) begin : g_ch
    speed_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .pulse_in(pulse_in[c]),
      .range(cfg_ff[c][speed_pkg::CFG_RANGE_LSB +: 2]),
      .period_ff(period[c]),
      .stale_ff(stale[c])
    );
  end

  // time base enables
  wire tick = tick_cnt_ff == 15'(TICK_CYC - 1);
  wire ms_tick = ms_cnt_ff == 18'(MS_CYC - 1);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_ff <= '0;
      ms_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? 15'h0000 : tick_cnt_ff + 15'h0001;
      ms_cnt_ff <= ms_tick ? 18'h00000 : ms_cnt_ff + 18'h00001;
    end
  end

  // register decode
  wire wr_ctrl = wr_en && addr == speed_pkg::A_CTRL;
  wire wr_fcode = wr_en && addr == speed_pkg::A_FCODE;
  wire wr_key = wr_en && addr == speed_pkg::A_KEY;
  wire is_cfg = addr[5:2] == speed_pkg::A_CHCFG[5:2];
  wire is_dpr = addr[5:3] == speed_pkg::A_DPR[5:3];
  wire [1:0] sel_ch = addr[1:0];
  wire [1:0] dpr_ch = addr[2:1];

  // host configuration: range, filter shift and rate group per channel
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < N; c++) cfg_ff[c] <= speed_pkg::CFG_RST;
      ctrl_ff <= '0;
      fcode_ff <= '0;
      key_ff <= '0;
    end else begin
      if (wr_en && is_cfg) cfg_ff[sel_ch] <= wdata[9:0]; // R13
      if (wr_ctrl) ctrl_ff <= wdata[1:0];
      if (wr_fcode) fcode_ff <= wdata[4:0];
      if (wr_key) key_ff <= wdata[7:0];
    end
  end

  // divider and filter sequencer, one channel at a time
  wire [24:0] sh = {rem_ff[23:0], quo_ff[31]};
  wire [25:0] diff = {1'b0, sh} - {2'b00, dvs_ff};
  wire ge = !diff[25];
  wire [15:0] spd_raw = bad_ff ? 16'h0000 : // R15
    (|quo_ff[31:16] ? 16'hFFFF : quo_ff[15:0]); // R7
  wire [4:0] k = cfg_ff[ch_ff][speed_pkg::CFG_K_LSB +: 5];
  wire signed [24:0] x_in = {1'b0, spd_raw, speed_pkg::FRAC_ZERO};
  wire signed [24:0] y1_n = y1_ff[ch_ff] + ((x_in - y1_ff[ch_ff]) >>> k);
  wire signed [24:0] y2_n = y2_ff[ch_ff] + ((y1_n - y2_ff[ch_ff]) >>> k);
  wire signed [24:0] d_in = (y2_n - y2_ff[ch_ff]) <<< speed_pkg::DERIV_SHIFT;
  wire signed [24:0] dv_n = dv_ff[ch_ff] + ((d_in - dv_ff[ch_ff]) >>> k);
  wire [23:0] per_c = period[ch_ff];
  wire [23:0] per_n = period[ch_ff + 2'h1];
  wire bad_n = stale[ch_ff + 2'h1] || per_n == '0;

  // a tick that lands mid-sweep is skipped; a sweep takes 132 cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= speed_pkg::C_IDLE;
      ch_ff <= '0;
      bit_ff <= '0;
      rem_ff <= '0;
      quo_ff <= '0;
      dvs_ff <= '0;
      bad_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        speed_pkg::C_IDLE: begin
          if (tick) begin // R3
            st_ff <= speed_pkg::C_DIV;
            ch_ff <= '0;
            bit_ff <= '0;
            rem_ff <= '0;
            quo_ff <= speed_pkg::SPEED_NUM;
            dvs_ff <= period[0];
            bad_ff <= stale[0] || period[0] == '0;
          end
        end
        speed_pkg::C_DIV: begin
          rem_ff <= ge ? diff[24:0] : sh; // R3
          quo_ff <= {quo_ff[30:0], ge};
          bit_ff <= bit_ff + 5'h01;
          if (bit_ff == speed_pkg::DIV_LAST) st_ff <= speed_pkg::C_FILT;
        end
        speed_pkg::C_FILT: begin
          if (ch_ff == 2'(N - 1)) begin
            st_ff <= speed_pkg::C_IDLE;
          end else begin
            st_ff <= speed_pkg::C_DIV;
            ch_ff <= ch_ff + 2'h1;
            bit_ff <= '0;
            rem_ff <= '0;
            quo_ff <= speed_pkg::SPEED_NUM;
            dvs_ff <= per_n;
            bad_ff <= bad_n;
          end
        end
      endcase
    end
  end

  // two cascaded poles for speed, a third on the derivative
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < N; c++) begin
        y1_ff[c] <= '0;
        y2_ff[c] <= '0;
        dv_ff[c] <= '0;
      end
    end else if (st_ff == speed_pkg::C_FILT) begin
      y1_ff[ch_ff] <= y1_n; // R4 R8
      y2_ff[ch_ff] <= y2_n; // R8
      dv_ff[ch_ff] <= dv_n; // R5 R8
    end
  end

  // key broadcast marks due channels; a new mark wins over the publish clear
  logic [3:0] due;
  always_comb begin
    for (int c = 0; c < N; c++)
      due[c] = wr_key && wdata[cfg_ff[c][speed_pkg::CFG_GRP_LSB +: 3]];
  end
  wire [1:0] pub_ch = pend_ff[0] ? 2'h0 : pend_ff[1] ? 2'h1 :
    pend_ff[2] ? 2'h2 : 2'h3;
  wire pub_valid = |pend_ff;
  logic pub_ready;
  speed_pkg::pub_t pub_in;
  speed_pkg::pub_t pub_out;
  logic out_valid;
  wire out_ready = !rd_en; // host reads take the RAM port first
  assign pub_in.ch = pub_ch;
  assign pub_in.speed = y2_ff[pub_ch][23:8];
  assign pub_in.deriv = dv_ff[pub_ch][23:8];
  wire [3:0] pub_clr = (pub_valid && pub_ready) ? 4'h1 << pub_ch : 4'h0;

  always_ff @(posedge clk_sys) begin
    if (rst) pend_ff <= '0;
    else pend_ff <= (pend_ff & ~pub_clr) | due; // R14
  end

  pub_fifo #(
    .W($bits(speed_pkg::pub_t)),
    .DEPTH(speed_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(pub_valid),
    .in_ready(pub_ready),
    .in_data(pub_in),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(pub_out)
  );

  // result RAM the host reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int c = 0; c < N; c++) begin
        spd_ram[c] <= '0;
        drv_ram[c] <= '0;
      end
    end else if (out_valid && out_ready) begin
      spd_ram[pub_out.ch] <= pub_out.speed; // R6
      drv_ram[pub_out.ch] <= pub_out.deriv; // R6
    end
  end

  // diagnostics result: pass needs both init and diag bits
  always_ff @(posedge clk_sys) begin
    if (rst) ok_ff <= 1'b0; // R10
    else if (wr_ctrl) ok_ff <= wdata[speed_pkg::CTRL_INIT] &&
      wdata[speed_pkg::CTRL_DIAG]; // R11
  end

  // flash code: n pulses, then a long gap, repeating
  // a phase ends on its last ms so it lasts exactly its count, not one more
  wire [9:0] on_last = speed_pkg::FLASH_ON_MS - 10'h001;
  wire [9:0] off_last = speed_pkg::FLASH_OFF_MS - 10'h001;
  wire [9:0] gap_last = speed_pkg::FLASH_GAP_MS - 10'h001;
  wire fl_done = (fl_ff == speed_pkg::F_ON && fl_ms_ff == on_last)
    || (fl_ff == speed_pkg::F_OFF && fl_ms_ff == off_last)
    || (fl_ff == speed_pkg::F_GAP && fl_ms_ff == gap_last);
  always_ff @(posedge clk_sys) begin
    if (rst || fcode_ff == '0) begin
      fl_ff <= speed_pkg::F_GAP;
      fl_ms_ff <= '0;
      fl_n_ff <= '0;
    end else if (ms_tick) begin
      fl_ms_ff <= fl_done ? 10'h000 : fl_ms_ff + 10'h001;
      if (fl_done) begin
        unique case (fl_ff)
          speed_pkg::F_ON: begin
            fl_ff <= speed_pkg::F_OFF;
            fl_n_ff <= fl_n_ff + 5'h01; // R12
          end
          speed_pkg::F_OFF: fl_ff <= (fl_n_ff == fcode_ff) ?
            speed_pkg::F_GAP : speed_pkg::F_ON; // R12
          speed_pkg::F_GAP: begin
            fl_ff <= speed_pkg::F_ON;
            fl_n_ff <= '0;
          end
        endcase
      end
    end
  end

  // indicators; an active code overrides the run state
  wire flashing = fcode_ff != '0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_ff <= 1'b1; // R10
      run_ff <= 1'b0;
    end else begin
      fault_ff <= flashing ? fl_ff == speed_pkg::F_ON : !ok_ff; // R11 R12
      run_ff <= ok_ff && !flashing; // R11
    end
  end
  assign fault_indicator = fault_ff;
  assign run_indicator = run_ff;

  // read mux; unmapped words read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (addr == speed_pkg::A_CTRL)
      rd_mux = {28'h0, run_ff, fault_ff, ctrl_ff};
    else if (addr == speed_pkg::A_FCODE)
      rd_mux = {27'h0, fcode_ff};
    else if (addr == speed_pkg::A_KEY)
      rd_mux = {20'h0, pend_ff, key_ff};
    else if (is_cfg)
      rd_mux = {21'h0, CH_TYPE[sel_ch], cfg_ff[sel_ch]}; // R9
    else if (is_dpr)
      rd_mux = {16'h0000, addr[0] ? drv_ram[dpr_ch] : spd_ram[dpr_ch]};
  end
  always_ff @(posedge clk_sys) begin
    if (rst) rd_data_ff <= '0;
    else if (rd_en) rd_data_ff <= rd_mux;
  end
  assign rd_data = rd_data_ff;
  wire unused_ok = &{1'b0, per_c, y1_ff[0][24], dv_ff[0][24]};
endmodule : speed_period_measure_unit

`default_nettype wire

// ===== spmu_asserts.sv
// checker for the speed unit: host port read timing and lamp sequencing
// sees only the top module's ports; bound to every instance at the foot
`timescale 1ns/1ns
`default_nettype none
module spmu_asserts #(
  parameter logic [3:0] CH_TYPE = 4'h0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] pulse_in,
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic fault_indicator,
  input wire logic run_indicator
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] code_ff;
  wire ctrl_wr = wr_en && addr == speed_pkg::A_CTRL;
  // shadow of the flash code, since a live code overrides both lamps
  always_ff @(posedge clk_sys) begin
    if (rst) code_ff <= 5'h00;
    else if (wr_en && addr == speed_pkg::A_FCODE) code_ff <= wdata[4:0];
  end
  // a lone status write: the quiet cycle after keeps a later write out
  sequence s_ok_wr;
    ctrl_wr && wdata[1:0] == 2'h3 && code_ff == 5'h00 ##1 !wr_en;
  endsequence
  sequence s_bad_wr;
    ctrl_wr && wdata[1:0] != 2'h3 && code_ff == 5'h00 ##1 !wr_en;
  endsequence
  property p_rst_lamps;
    $fell(rst) |-> fault_indicator && !run_indicator;
  endproperty
  a_rst_lamps: assert property (p_rst_lamps)
    else $error("lamps wrong after reset");
  property p_lamps_excl;
    !(fault_indicator && run_indicator);
  endproperty
  a_lamps_excl: assert property (p_lamps_excl)
    else $error("fault and run lit together");
  property p_ok_run;
    s_ok_wr |=> run_indicator && !fault_indicator;
  endproperty
  a_ok_run: assert property (p_ok_run)
    else $error("run lamp not on after passed diagnostics");
  property p_bad_run;
    s_bad_wr |=> fault_indicator && !run_indicator;
  endproperty
  a_bad_run: assert property (p_bad_run)
    else $error("fault lamp not on after failed diagnostics");
  property p_code_run;
    code_ff != 5'h00 |=> !run_indicator;
  endproperty
  a_code_run: assert property (p_code_run)
    else $error("run lamp on while a flash code is active");
  property p_rd_hold;
    !$past(rd_en) && !$past(rst) |-> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_type_ro;
    rd_en && addr[5:2] == 4'h1 |=>
      rd_data[10] == CH_TYPE[$past(addr[1:0])];
  endproperty
  a_type_ro: assert property (p_type_ro)
    else $error("input type bit differs from build value");
  property p_ram_w16;
    rd_en && addr[5:3] == 3'h2 |=> rd_data[31:16] == 16'h0000;
  endproperty
  a_ram_w16: assert property (p_ram_w16)
    else $error("result word wider than 16 bits");
endmodule : spmu_asserts

bind speed_period_measure_unit spmu_asserts #(.CH_TYPE(CH_TYPE)) chk_u (
  .clk_sys(clk_sys), .rst(rst), .pulse_in(pulse_in), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .fault_indicator(fault_indicator), .run_indicator(run_indicator));
`default_nettype wire

// ===== host_bus_model.sv
// host side model: drives the register port one access at a time
// assumes callers start each access just after a rising edge or mid-cycle
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic clk_sys,
  output logic [5:0] addr,
  output logic [31:0] wdata,
  output logic wr_en,
  output logic rd_en,
  input wire logic [31:0] rd_data
);
  // idle bus at time zero
  initial begin
    addr = 6'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // strobe for one cycle; a new access waits an edge, so no double drive
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  // data stand from the cycle after the strobe until the next read, taken mid-cycle
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ===== speed_period_measure_unit_tb_top.sv
// self-checking bench: registers, lamps, speed publish and flash codes
// short tick and ms counts so the run stays small
`timescale 1ns/1ns
`default_nettype none
module speed_period_measure_unit_tb_top;
  localparam logic [3:0] TYPE = 4'h5;
  localparam int MSC = 4;
  typedef struct packed {
    logic [5:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_t;
  logic clk_sys;
  logic rst;
  logic [3:0] pulse_in;
  logic [5:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic fault_indicator;
  logic run_indicator;
  logic [31:0] d;
  logic [15:0] es [4];
  logic fl_prev;
  int per [4];
  int pcnt [4];
  int mismatches;
  int compares;
  int n;
  int w;
  row_t rows [6];

  speed_period_measure_unit #(.TICK_CYC(50), .MS_CYC(MSC), .CH_TYPE(TYPE))
    dut_u (.clk_sys(clk_sys), .rst(rst), .pulse_in(pulse_in), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .fault_indicator(fault_indicator), .run_indicator(run_indicator));
  host_bus_model host_u (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // pickup pulses, one cycle high every per[i] cycles; per of 0 is silent
  always @(posedge clk_sys) begin
    for (int i = 0; i < 4; i++) begin
      pcnt[i] <= (pcnt[i] + 1 >= per[i]) ? 0 : pcnt[i] + 1;
      pulse_in[i] <= per[i] != 0 && pcnt[i] == 0;
    end
  end
  // a hang anywhere still ends in the one closing report
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  function automatic logic [15:0] spd(input int p);
    logic [31:0] q;
    q = 32'h0FFF_FFFF / p;
    return (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
  endfunction : spd
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial begin
    rst = 1'b1;
    per = '{0, 0, 0, 0};
    rows = '{'{6'h04, 32'h0, 32'h400}, '{6'h05, 32'h7FF, 32'h3FF},
      '{6'h01, 32'h13, 32'h13}, '{6'h01, 32'h0, 32'h0},
      '{6'h03, 32'hFFFF, 32'h0}, '{6'h00, 32'h1, 32'h5}};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("fault", {31'h0, fault_indicator}, 32'h1);
    chk("run", {31'h0, run_indicator}, 32'h0);
    host_u.rd(6'h06, d);
    chk("cfg2", d, 32'h418);
    $display("test reset done");
    // read back what was written; reserved bits and holes read zero
    for (int i = 0; i < 6; i++) begin
      host_u.wr(rows[i].a, rows[i].w);
      host_u.rd(rows[i].a, d);
      chk("reg", d, rows[i].e);
    end
    $display("test regs done");
    host_u.wr(6'h00, 32'h3);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("run", {fault_indicator, run_indicator}, 32'h1);
    host_u.wr(6'h00, 32'h1);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("fault", {fault_indicator, run_indicator}, 32'h2);
    $display("test lamps done");
    // ch0 plain, ch1 prescaled by 4, ch2 silent, ch3 in another group
    host_u.wr(6'h04, 32'h080);
    host_u.wr(6'h05, 32'h082);
    host_u.wr(6'h06, 32'h080);
    host_u.wr(6'h07, 32'h100);
    per = '{4100, 1025, 0, 8200};
    repeat (4 * 8200) @(posedge clk_sys);
    host_u.wr(6'h02, 32'h02);
    repeat (20) @(posedge clk_sys);
    es = '{spd(4100), spd(4100), 16'h0000, 16'h0000};
    for (int c = 0; c < 4; c++) begin
      host_u.rd(speed_pkg::A_DPR + 6'(2 * c), d);
      chk("speed", d, {16'h0, es[c]});
      host_u.rd(speed_pkg::A_DPR + 6'(2 * c + 1), d);
      chk("deriv", d, 32'h0);
    end
    host_u.wr(6'h02, 32'h04);
    repeat (20) @(posedge clk_sys);
    host_u.rd(6'h16, d);
    chk("speed3", d, {16'h0, spd(8200)});
    $display("test speed done");
    // flash code 2: gap first, then two pulses of 250 ms
    host_u.wr(6'h00, 32'h3);
    host_u.wr(6'h01, 32'h2);
    n = 0;
    w = 0;
    fl_prev = fault_indicator;
    for (int t = 0; t < 2500 * MSC; t++) begin
      @(negedge clk_sys);
      if (fault_indicator && !fl_prev) n++;
      if (n == 1 && fault_indicator) w++;
      fl_prev = fault_indicator;
    end
    chk("flashes", 32'(n), 32'h2);
    chk("width", 32'(w), 32'(250 * MSC));
    host_u.wr(6'h01, 32'h0);
    $display("test flash done");
    // mid-run reset: lamps and result RAM go back to their reset state
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("fault2", {31'h0, fault_indicator}, 32'h1);
    chk("run2", {31'h0, run_indicator}, 32'h0);
    host_u.rd(6'h10, d);
    chk("ram2", d, 32'h0);
    $display("test reset2 done");
    stop_test();
  end
endmodule : speed_period_measure_unit_tb_top
`default_nettype wire
